// *** inc/ccwe_pkg.sv ***
// Package for the call, clear and watchdog-clear execution block
`default_nettype none
package ccwe_pkg;
  localparam int PC_W = 11;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int BIT_W = 3;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [DW-1:0] BYTE_CLEAR = 8'h00;
  localparam logic [DW-1:0] BIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    CCWE_OP_NONE = 3'h0,
    CCWE_OP_CALL = 3'h1,
    CCWE_OP_CLR_BYTE = 3'h2,
    CCWE_OP_CLR_BIT = 3'h3,
    CCWE_OP_WD_SINGLE = 3'h4,
    CCWE_OP_WD_FIRST = 3'h5,
    CCWE_OP_WD_SECOND = 3'h6
  } ccwe_op_t;

  // Last pre-clear seen; NONE means neither yet
  typedef enum logic [1:0] {
    CCWE_PRE_NONE = 2'h0,
    CCWE_PRE_FIRST = 2'h1,
    CCWE_PRE_SECOND = 2'h3
  } ccwe_pre_t;

  typedef enum logic {
    CCWE_ST_EXEC = 1'b0,
    CCWE_ST_CALL2 = 1'b1
  } ccwe_state_t;

  typedef struct packed {
    ccwe_op_t op;
    logic [PC_W-1:0] target;
    logic [AW-1:0] addr;
    logic [BIT_W-1:0] bit_sel;
  } ccwe_instr_t;

  typedef struct packed {
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } ccwe_mem_wr_t;
endpackage
`default_nettype wire

// *** src/ccwe_exec.sv ***
// Execution logic for subroutine call, memory clears and watchdog clears
`timescale 1ns/1ps
`default_nettype none
module ccwe_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire ccwe_pkg::ccwe_instr_t instr,
  output logic instr_ready,
  input wire logic [ccwe_pkg::PC_W-1:0] pc,
  input wire logic [ccwe_pkg::DW-1:0] mem_rdata,
  output logic [ccwe_pkg::AW-1:0] mem_raddr,
  output ccwe_pkg::ccwe_mem_wr_t mem_wr,
  output logic stack_push,
  output logic [ccwe_pkg::PC_W-1:0] stack_data,
  output logic pc_load,
  output logic [ccwe_pkg::PC_W-1:0] pc_target,
  output logic watchdog_counter_clear,
  output logic time_out_flag_clear,
  output logic power_down_flag_clear
);
  import ccwe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when the offered instruction carries the given operation
  function automatic logic op_is(
    input ccwe_instr_t ins,
    input ccwe_op_t code
  );
    return ins.op == code;
  endfunction

  // Return address wraps at the top of program space, as the counter does
  function automatic logic [PC_W-1:0] ret_addr(
    input logic [PC_W-1:0] cur
  );
    return PC_W'(cur + PC_STEP);
  endfunction

  // Clears one bit and keeps the other seven as they were read
  function automatic logic [DW-1:0] clear_one(
    input logic [DW-1:0] data,
    input logic [BIT_W-1:0] sel
  );
    logic [DW-1:0] mask;
    mask = BIT_ONE << sel;
    return data & ~mask;
  endfunction

  // A pre-clear counts unless the last one seen was of the same kind
  function automatic logic pre_acts(
    input ccwe_pre_t last,
    input ccwe_pre_t kind
  );
    return last != kind;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and next values

  ccwe_state_t state_r;
  ccwe_state_t state_nxt;
  ccwe_pre_t pre_r;
  ccwe_pre_t pre_nxt;
  logic [PC_W-1:0] tgt_r;
  logic [PC_W-1:0] tgt_nxt;
  ccwe_mem_wr_t wr_nxt;
  logic [DW-1:0] wr_data;
  logic push_nxt;
  logic [PC_W-1:0] ret_nxt;
  logic load_nxt;
  logic [PC_W-1:0] jump_nxt;
  logic wd_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic take;
  wire logic is_call;
  wire logic is_byte;
  wire logic is_bit;
  wire logic is_single;
  wire logic is_first;
  wire logic is_second;
  wire logic first_ok;
  wire logic second_ok;

  // Nothing is accepted while a call spends its second cycle
  assign instr_ready = (state_r == CCWE_ST_EXEC);
  assign take = instr_valid && instr_ready;
  // No condition is tested: every call offered while instr_ready is high is taken
  assign is_call = take && op_is(instr, CCWE_OP_CALL);
  assign is_byte = take && op_is(instr, CCWE_OP_CLR_BYTE);
  assign is_bit = take && op_is(instr, CCWE_OP_CLR_BIT);
  assign is_single = take && op_is(instr, CCWE_OP_WD_SINGLE);
  assign is_first = take && op_is(instr, CCWE_OP_WD_FIRST);
  assign is_second = take && op_is(instr, CCWE_OP_WD_SECOND);

  ////////////////////////////////////////////////////////////////////////
  // Watchdog clear pairing

  // The first pre-clear after reset acts, since the history holds none
  assign first_ok = is_first
    && pre_acts(pre_r, CCWE_PRE_FIRST);
  assign second_ok = is_second
    && pre_acts(pre_r, CCWE_PRE_SECOND);
  assign wd_nxt = is_single || first_ok || second_ok;

  // A repeated pre-clear still records itself; the single clear leaves
  // the history alone so that it cannot break up a pair
  always_comb begin
    pre_nxt = pre_r;
    if (is_first) begin
      pre_nxt = CCWE_PRE_FIRST;
    end else if (is_second) begin
      pre_nxt = CCWE_PRE_SECOND;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Call sequencing

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CCWE_ST_EXEC: begin
        if (is_call) begin
          state_nxt = CCWE_ST_CALL2;
        end
      end
      CCWE_ST_CALL2: begin
        state_nxt = CCWE_ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Call path

  assign tgt_nxt = is_call ? instr.target : tgt_r;
  assign push_nxt = is_call;
  assign ret_nxt = is_call ? ret_addr(pc) : stack_data;
  // The redirect is the extra operation that costs the second cycle
  assign load_nxt = (state_r == CCWE_ST_CALL2);
  assign jump_nxt = load_nxt ? tgt_r : pc_target;

  ////////////////////////////////////////////////////////////////////////
  // Memory clears

  // The read address follows the offer so the byte is back in time
  assign mem_raddr = instr.addr;
  assign wr_data = is_bit ? clear_one(mem_rdata, instr.bit_sel)
                          : BYTE_CLEAR;
  assign wr_nxt = '{
    we: is_byte || is_bit,
    addr: instr.addr,
    data: wr_data
  };

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= CCWE_ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= CCWE_PRE_NONE;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_r <= '0;
    end else begin
      tgt_r <= tgt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr <= '0;
    end else begin
      mem_wr <= wr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_push <= 1'b0;
      stack_data <= '0;
    end else begin
      stack_push <= push_nxt;
      stack_data <= ret_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load <= 1'b0;
      pc_target <= '0;
    end else begin
      pc_load <= load_nxt;
      pc_target <= jump_nxt;
    end
  end

  // Status flags are only ever touched by the watchdog clears; the three
  // strobes stay separate so the counter and flags may sit apart
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_counter_clear <= 1'b0;
      time_out_flag_clear <= 1'b0;
      power_down_flag_clear <= 1'b0;
    end else begin
      watchdog_counter_clear <= wd_nxt;
      time_out_flag_clear <= wd_nxt;
      power_down_flag_clear <= wd_nxt;
    end
  end
endmodule
`default_nettype wire

// *** sim/ccwe_checker.sv ***
// Assertion checker for the call, clear and watchdog-clear block
`timescale 1ns/1ps
`default_nettype none
module ccwe_checker import ccwe_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic stack_push,
  input wire logic pc_load,
  input wire ccwe_instr_t instr,
  input wire logic [PC_W-1:0] pc,
  input wire logic [PC_W-1:0] stack_data,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic [DW-1:0] mem_rdata,
  input wire ccwe_mem_wr_t mem_wr,
  input wire logic watchdog_counter_clear,
  input wire logic time_out_flag_clear,
  input wire logic power_down_flag_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic tk = instr_valid && instr_ready;
  wire logic call = tk && instr.op == CCWE_OP_CALL;
  wire logic pre = tk && instr.op inside {CCWE_OP_WD_FIRST, CCWE_OP_WD_SECOND};
  wire logic mw = tk && instr.op inside {CCWE_OP_CLR_BYTE, CCWE_OP_CLR_BIT};
  wire logic [2:0] wd = {watchdog_counter_clear, time_out_flag_clear,
    power_down_flag_clear};
  logic [2:0] pre_r;
  // A single clear must not disturb the pairing history
  always_ff @(posedge clk)
    if (rst) pre_r <= 3'h0;
    else if (pre) pre_r <= instr.op;
  //////////////////////////////////////////////////////////////////////////
  push_a: assert property (call |=> stack_push &&
    stack_data == $past(pc) + PC_STEP) else $error("bad push");
  jump_a: assert property (call |=> ##1 pc_load &&
    pc_target == $past(instr.target, 2)) else $error("bad jump");
  stall_a: assert property (call |=> !instr_ready ##1 instr_ready)
    else $error("bad stall");
  byte_a: assert property (tk && instr.op == CCWE_OP_CLR_BYTE |=>
    mem_wr == {1'b1, $past(instr.addr), BYTE_CLEAR}) else $error("bad clr");
  bit_a: assert property (tk && instr.op == CCWE_OP_CLR_BIT |=>
    mem_wr.we && mem_wr.addr == $past(instr.addr) &&
    mem_wr.data == ($past(mem_rdata) & ~(BIT_ONE << $past(instr.bit_sel))))
    else $error("bad bit clr");
  single_a: assert property (tk && instr.op == CCWE_OP_WD_SINGLE |=>
    wd == 3'h7) else $error("no wd clear");
  alt_a: assert property (pre && instr.op != pre_r |=> wd == 3'h7)
    else $error("no alt clear");
  rep_a: assert property (pre && instr.op == pre_r |=> wd == 3'h0)
    else $error("repeat acted");
  quiet_flags_a: assert property (call || mw |=> wd == 3'h0)
    else $error("flags touched");
  one_cycle_a: assert property (tk && !call |=> instr_ready)
    else $error("clear stalled");
  call_c: cover property (call ##2 pc_load);
  alt_c: cover property (pre && instr.op != pre_r);
  rep_c: cover property (pre && instr.op == pre_r);
endmodule
bind ccwe_exec ccwe_checker chk (.*);
`default_nettype wire

// *** sim/call_clear_watchdog_exec_bench.sv ***
// Self-checking bench for the call, clear and watchdog-clear block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t mismatch", $time); end end
module call_clear_watchdog_exec_bench;
  import ccwe_pkg::*;
  logic clk = 0, rst = 1, instr_valid = 0, instr_ready, stack_push, pc_load;
  logic watchdog_counter_clear, time_out_flag_clear, power_down_flag_clear;
  ccwe_instr_t instr = '0;
  logic [PC_W-1:0] pc = 11'h7ff, stack_data, pc_target;
  logic [DW-1:0] mem_rdata = 8'hb6, mem_raddr;
  ccwe_mem_wr_t mem_wr;
  wire logic [2:0] wdc = {watchdog_counter_clear, time_out_flag_clear,
    power_down_flag_clear};
  int n_fail = 0, n_checks = 0;
  ccwe_exec uut (.*);
  initial forever #2.5 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(ccwe_op_t op, logic [2:0] bs);
    @(posedge clk);
    instr <= '{op, 11'h2a5, 8'h3c, bs};
    instr_valid <= 1;
    @(posedge clk);
    instr_valid <= 0;
    #1;
  endtask
  task automatic t_call();
    issue(CCWE_OP_CALL, 0);
    `CHK({stack_push, instr_ready, stack_data}, 13'h1000)
    `CHK(wdc, 3'h0)
    @(posedge clk) #1;
    `CHK({pc_load, instr_ready, pc_target}, 13'h1aa5)
  endtask
  task automatic t_clear();
    issue(CCWE_OP_CLR_BYTE, 5);
    `CHK({mem_wr, wdc, instr_ready}, {17'h13c00, 3'h0, 1'b1})
    `CHK(mem_raddr, 8'h3c)
    for (int i = 0; i < 8; i++) begin
      issue(CCWE_OP_CLR_BIT, i[2:0]);
      `CHK({mem_wr, wdc}, {9'h13c, 8'hb6 & ~(8'h01 << i), 3'h0})
    end
  endtask
  task automatic wd(ccwe_op_t op, logic e);
    issue(op, 0);
    `CHK(wdc, {3{e}})
  endtask
  task automatic t_watch();
    wd(CCWE_OP_WD_SINGLE, 1);
    wd(CCWE_OP_WD_FIRST, 1);
    wd(CCWE_OP_WD_FIRST, 0);
    wd(CCWE_OP_WD_SECOND, 1);
    wd(CCWE_OP_WD_SECOND, 0);
    wd(CCWE_OP_WD_SINGLE, 1);
    wd(CCWE_OP_WD_FIRST, 1);
    wd(CCWE_OP_WD_SINGLE, 1);
    wd(CCWE_OP_WD_FIRST, 0);
  endtask
  // Mid-run reset must forget the pre-clear history
  task automatic t_reset();
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    #1;
    `CHK({instr_ready, stack_push, pc_load, wdc, mem_wr}, 23'h400000)
    wd(CCWE_OP_WD_FIRST, 1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_call();
    t_clear();
    t_watch();
    t_reset();
    give_verdict();
  end
  // Run needs about 55 cycles; allow seven times that
  initial begin
    #2000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
